// *** oscillator_control_status_regs.sv ***
// Oscillator control, clock divisor, feedback divisor and fast RC tuning registers.
// Assumes resetn is the power-on reset and that the lock and fail inputs are asynchronous.
//
// The address map and the strobed register port were chosen for this implementation.
module oscillator_control_status_regs (
	input wire logic clk, // System clock
	input wire logic resetn, // Power-on reset, active low
	input wire osc_ctrl_pkg::addr_t addr, // Register address
	input wire osc_ctrl_pkg::data_t wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output osc_ctrl_pkg::data_t rdata, // Read data, cycle after rd
	input wire logic [osc_ctrl_pkg::SRC_W-1:0] initialSourceSel, // Configured start-up source
	input wire logic pllLockIn, // PLL lock level, asynchronous
	input wire logic clockFailIn, // Clock fail level, asynchronous
	output logic [osc_ctrl_pkg::SRC_W-1:0] currentSource, // Active clock source
	output logic switchBusy, // Clock switch in progress
	output logic pinSelectLock, // Pin select lock
	output logic secondaryOscEnable, // Secondary oscillator enable
	output logic [osc_ctrl_pkg::DOZE_W-1:0] dozeRatio, // Doze ratio
	output logic dozeEnable, // Doze mode enable
	output logic [osc_ctrl_pkg::FRC_POST_W-1:0] frcPostscale, // Fast RC postscaler
	output logic [osc_ctrl_pkg::PLL_POST_W-1:0] pllPostscale, // PLL postscaler
	output logic [osc_ctrl_pkg::PLL_PRE_W-1:0] pllPrescale, // PLL prescaler
	output logic [osc_ctrl_pkg::PLL_FBD_W-1:0] pllFeedbackDiv, // PLL feedback divisor
	output logic [osc_ctrl_pkg::FRC_TUN_W-1:0] frcTuning // Fast RC trim value
);
	import osc_ctrl_pkg::*;

	// Control register state
	logic strapTaken_reg;
	logic [SRC_W-1:0] curSrc_reg;
	logic [SRC_W-1:0] newSrc_reg;
	logic lockEn_reg;
	logic pinLock_reg;
	logic clkFail_reg;
	logic secOsc_reg;
	logic switchReq_reg;

	// Synchroniser stages
	logic pllSync1_reg;
	logic pllSync2_reg;
	logic failSync1_reg;
	logic failSync2_reg;
	logic failSync3_reg;

	// Divisor, feedback and tuning state
	logic [DOZE_W-1:0] doze_reg;
	logic dozeEn_reg;
	logic [FRC_POST_W-1:0] frcPost_reg;
	logic [PLL_POST_W-1:0] pllPost_reg;
	logic [PLL_PRE_W-1:0] pllPre_reg;
	logic [PLL_FBD_W-1:0] pll_feedback_divisor_reg_reg;
	logic [FRC_TUN_W-1:0] frcTun_reg;

	// Sequencer, read path and decode
	sw_state_e swState_reg;
	logic [SW_CNT_W-1:0] swCnt_reg;
	data_t rdata_reg;
	data_t rdata_next;
	logic wrOsc;
	logic wrDiv;
	logic wrFbd;
	logic wrTun;
	logic failRise;
	logic reqAccept;
	logic switchDone;
	logic reqCancel;

	// Write decode
	assign wrOsc = wr && (addr == OFF_OSC_CTRL);
	assign wrDiv = wr && (addr == OFF_CLK_DIV);
	assign wrFbd = wr && (addr == OFF_PLL_FBD);
	assign wrTun = wr && (addr == OFF_FRC_TUN);

	// Switch request accepted only when lock is clear and not being set now
	assign reqAccept = wrOsc && wdata[SWITCH_REQ_BIT] && !lockEn_reg
		&& !wdata[LOCK_EN_BIT];
	assign switchDone = (swState_reg == SW_BUSY) && (swCnt_reg == SW_CNT_W'(1));
	assign failRise = failSync2_reg && !failSync3_reg;
	// A pending request dropped by a write keeps the sequencer idle as well
	assign reqCancel = wrOsc && !reqAccept && (swState_reg == SW_IDLE);

	// Synchronisers for the PLL lock and clock fail levels
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pllSync1_reg <= 1'b0;
			pllSync2_reg <= 1'b0;
			failSync1_reg <= 1'b0;
			failSync2_reg <= 1'b0;
			failSync3_reg <= 1'b0;
		end else begin
			pllSync1_reg <= pllLockIn;
			pllSync2_reg <= pllSync1_reg;
			failSync1_reg <= clockFailIn;
			failSync2_reg <= failSync1_reg;
			failSync3_reg <= failSync2_reg;
		end
	end

	// Start-up source caught once after power-on release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			strapTaken_reg <= 1'b0;
		end else begin
			strapTaken_reg <= 1'b1;
		end
	end

	// Current source: start-up value, then the new source after a switch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			curSrc_reg <= SRC_FAST_RC;
		end else if (!strapTaken_reg) begin
			curSrc_reg <= initialSourceSel;
		end else if (switchDone) begin
			curSrc_reg <= newSrc_reg;
		end
	end

	// New source field, writable by software
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			newSrc_reg <= SRC_FAST_RC;
		end else if (!strapTaken_reg) begin
			newSrc_reg <= initialSourceSel;
		end else if (wrOsc) begin
			newSrc_reg <= wdata[NEW_SRC_LSB +: SRC_W];
		end
	end

	// Switch lock enable: set by software, cleared only by power-on reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lockEn_reg <= 1'b0;
		end else if (wrOsc && wdata[LOCK_EN_BIT]) begin
			lockEn_reg <= 1'b1;
		end
	end

	// Pin select lock and secondary oscillator enable, plain read-write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinLock_reg <= 1'b0;
			secOsc_reg <= 1'b0;
		end else if (wrOsc) begin
			pinLock_reg <= wdata[PIN_LOCK_BIT];
			secOsc_reg <= wdata[SEC_OSC_BIT];
		end
	end

	// Clock fail flag: hardware sets, software clears by writing zero, set wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clkFail_reg <= 1'b0;
		end else if (failRise) begin
			clkFail_reg <= 1'b1;
		end else if (wrOsc && !wdata[CLK_FAIL_BIT]) begin
			clkFail_reg <= 1'b0;
		end
	end

	// Switch request: set by software when permitted, cleared when the switch ends
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			switchReq_reg <= 1'b0;
		end else if (switchDone) begin
			switchReq_reg <= 1'b0;
		end else if (reqAccept) begin
			switchReq_reg <= 1'b1;
		end else if (reqCancel) begin
			switchReq_reg <= 1'b0; // Cancel before the switch starts
		end
	end

	// Clock switch sequencer: waits the settling time, then changes source
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			swState_reg <= SW_IDLE;
			swCnt_reg <= '0;
		end else begin
			case (swState_reg)
				SW_IDLE: begin
					if (switchReq_reg && !reqCancel) begin
						swState_reg <= SW_BUSY;
						swCnt_reg <= SW_CNT_W'(SWITCH_CYCLES);
					end
				end
				SW_BUSY: begin
					if (switchDone) begin
						swState_reg <= SW_IDLE;
						swCnt_reg <= '0;
					end else begin
						swCnt_reg <= swCnt_reg - SW_CNT_W'(1);
					end
				end
				default: begin
					swState_reg <= SW_IDLE;
					swCnt_reg <= '0;
				end
			endcase
		end
	end

	// Clock divisor fields
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			doze_reg <= DOZE_RESET;
			dozeEn_reg <= DOZE_EN_RESET;
			frcPost_reg <= FRC_POST_RESET;
			pllPost_reg <= PLL_POST_RESET;
			pllPre_reg <= PLL_PRE_RESET;
		end else if (wrDiv) begin
			doze_reg <= wdata[DOZE_LSB +: DOZE_W];
			dozeEn_reg <= wdata[DOZE_EN_BIT];
			frcPost_reg <= wdata[FRC_POST_LSB +: FRC_POST_W];
			pllPost_reg <= wdata[PLL_POST_LSB +: PLL_POST_W];
			pllPre_reg <= wdata[PLL_PRE_LSB +: PLL_PRE_W];
		end
	end

	// PLL feedback divisor
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pll_feedback_divisor_reg_reg <= PLL_FBD_RESET;
		end else if (wrFbd) begin
			pll_feedback_divisor_reg_reg <= wdata[PLL_FBD_W-1:0];
		end
	end

	// Fast RC tuning value, signed trim code
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frcTun_reg <= FRC_TUN_RESET;
		end else if (wrTun) begin
			frcTun_reg <= wdata[FRC_TUN_W-1:0];
		end
	end

	// Read mux; unmapped addresses and unused bits read zero
	always_comb begin
		rdata_next = '0;
		case (addr)
			OFF_OSC_CTRL: begin
				rdata_next[CUR_SRC_LSB +: SRC_W] = curSrc_reg;
				rdata_next[NEW_SRC_LSB +: SRC_W] = newSrc_reg;
				rdata_next[LOCK_EN_BIT] = lockEn_reg;
				rdata_next[PIN_LOCK_BIT] = pinLock_reg;
				rdata_next[PLL_LOCK_BIT] = pllSync2_reg;
				rdata_next[CLK_FAIL_BIT] = clkFail_reg;
				rdata_next[SEC_OSC_BIT] = secOsc_reg;
				rdata_next[SWITCH_REQ_BIT] = switchReq_reg;
			end
			OFF_CLK_DIV: begin
				rdata_next[DOZE_LSB +: DOZE_W] = doze_reg;
				rdata_next[DOZE_EN_BIT] = dozeEn_reg;
				rdata_next[FRC_POST_LSB +: FRC_POST_W] = frcPost_reg;
				rdata_next[PLL_POST_LSB +: PLL_POST_W] = pllPost_reg;
				rdata_next[PLL_PRE_LSB +: PLL_PRE_W] = pllPre_reg;
			end
			OFF_PLL_FBD: begin
				rdata_next[PLL_FBD_W-1:0] = pll_feedback_divisor_reg_reg;
			end
			OFF_FRC_TUN: begin
				rdata_next[FRC_TUN_W-1:0] = frcTun_reg;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	// Read data register, valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= '0;
		end else if (rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= '0;
		end
	end

	// Outputs straight from flip-flops
	assign rdata = rdata_reg;
	assign currentSource = curSrc_reg;
	assign switchBusy = switchReq_reg;
	assign pinSelectLock = pinLock_reg;
	assign secondaryOscEnable = secOsc_reg;
	assign dozeRatio = doze_reg;
	assign dozeEnable = dozeEn_reg;
	assign frcPostscale = frcPost_reg;
	assign pllPostscale = pllPost_reg;
	assign pllPrescale = pllPre_reg;
	assign pllFeedbackDiv = pll_feedback_divisor_reg_reg;
	assign frcTuning = frcTun_reg;

endmodule // oscillator_control_status_regs

// *** osc_ctrl_pkg.sv ***
// Constants, offsets, field layouts and encodings of the oscillator control registers.
// Assumes a 25 MHz system clock and a 16-bit plain register port.
package osc_ctrl_pkg;

	// Register port widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [DATA_W-1:0] data_t;

	// Register offsets
	localparam addr_t OFF_OSC_CTRL = 4'h0;
	localparam addr_t OFF_CLK_DIV = 4'h1;
	localparam addr_t OFF_PLL_FBD = 4'h2;
	localparam addr_t OFF_FRC_TUN = 4'h3;

	// Oscillator control field positions
	localparam int SRC_W = 3;
	localparam int CUR_SRC_LSB = 12;
	localparam int NEW_SRC_LSB = 8;
	localparam int LOCK_EN_BIT = 7;
	localparam int PIN_LOCK_BIT = 6;
	localparam int PLL_LOCK_BIT = 5;
	localparam int CLK_FAIL_BIT = 3;
	localparam int SEC_OSC_BIT = 1;
	localparam int SWITCH_REQ_BIT = 0;

	// Clock source encoding, shared by current and new source fields
	typedef enum logic [SRC_W-1:0] {
		SRC_FAST_RC,
		SRC_FAST_RC_PLL,
		SRC_PRIMARY,
		SRC_PRIMARY_PLL,
		SRC_SECONDARY,
		SRC_LOW_POWER_RC,
		SRC_FAST_RC_DIV16,
		SRC_FAST_RC_DIVN
	} source_e;

	// Clock divisor field positions and widths
	localparam int DOZE_W = 3;
	localparam int DOZE_LSB = 12;
	localparam int DOZE_EN_BIT = 11;
	localparam int FRC_POST_W = 3;
	localparam int FRC_POST_LSB = 8;
	localparam int PLL_POST_W = 2;
	localparam int PLL_POST_LSB = 6;
	localparam int PLL_PRE_W = 5;
	localparam int PLL_PRE_LSB = 0;

	// Feedback divisor and tuning widths
	localparam int PLL_FBD_W = 9;
	localparam int FRC_TUN_W = 6;

	// Reset values
	localparam logic [DOZE_W-1:0] DOZE_RESET = 3'h0;
	localparam logic DOZE_EN_RESET = 1'b0;
	localparam logic [FRC_POST_W-1:0] FRC_POST_RESET = 3'h0;
	localparam logic [PLL_POST_W-1:0] PLL_POST_RESET = 2'h0;
	localparam logic [PLL_PRE_W-1:0] PLL_PRE_RESET = 5'h00;
	localparam logic [PLL_FBD_W-1:0] PLL_FBD_RESET = 9'h000;
	localparam logic [FRC_TUN_W-1:0] FRC_TUN_RESET = 6'h00;

	// Clock switch settling time
	localparam int CLK_PERIOD_NS = 40;
	localparam int SWITCH_TIME_NS = 400;
	localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SW_CNT_W = 4;

	// Clock switch sequencer states
	typedef enum logic [0:0] {
		SW_IDLE,
		SW_BUSY
	} sw_state_e;

endpackage

// *** osc_ctrl_chk.sv ***
// Checker for the oscillator control register block.
// Sees only the block's ports; attached by the bind at the foot.
module osc_ctrl_chk
	import osc_ctrl_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic resetn, // Power-on reset
	input wire addr_t addr, // Address
	input wire data_t wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	input wire data_t rdata, // Read data
	input wire logic [2:0] currentSource, // Active source
	input wire logic switchBusy, // Switch pending
	input wire logic pinSelectLock, // Pin select lock
	input wire logic secondaryOscEnable, // Secondary oscillator enable
	input wire logic [2:0] dozeRatio, // Doze ratio
	input wire logic dozeEnable, // Doze enable
	input wire logic [2:0] frcPostscale, // Fast RC postscale
	input wire logic [1:0] pllPostscale, // PLL postscale
	input wire logic [4:0] pllPrescale, // PLL prescale
	input wire logic [8:0] pllFeedbackDiv, // Feedback divisor
	input wire logic [5:0] frcTuning // Trim value
);
	logic lockSeen_reg;
	logic [2:0] newSrc_reg;
	wire ctrlWr = wr && addr == OFF_OSC_CTRL;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Shadow of the lock bit and of the requested source
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lockSeen_reg <= 1'b0;
			newSrc_reg <= 3'h0;
		end else if (ctrlWr) begin
			lockSeen_reg <= lockSeen_reg | wdata[7];
			newSrc_reg <= wdata[10:8];
		end
	end
	property p_rd_idle; !rd |=> rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_req; ctrlWr && wdata[0] && !wdata[7] && !lockSeen_reg |=> switchBusy; endproperty
	a_req: assert property (p_req) else $error("switch request not taken");
	// Request stands for the settling count plus the pick-up cycle, eleven samples
	property p_done; $rose(switchBusy) |-> switchBusy [*8] ##1 switchBusy [*3] ##1 !switchBusy;
	endproperty
	a_done: assert property (p_done) else $error("switch time wrong");
	property p_lock; ctrlWr && lockSeen_reg && !switchBusy |=> !switchBusy; endproperty
	a_lock: assert property (p_lock) else $error("switch taken while locked");
	property p_src; $past(resetn, 2) && $changed(currentSource) |-> $fell(switchBusy); endproperty
	a_src: assert property (p_src) else $error("source changed without switch");
	property p_new; $fell(switchBusy) |-> currentSource == newSrc_reg; endproperty
	a_new: assert property (p_new) else $error("switched to wrong source");
	property p_ctl; ctrlWr |=> pinSelectLock == $past(wdata[6])
		&& secondaryOscEnable == $past(wdata[1]); endproperty
	a_ctl: assert property (p_ctl) else $error("control bits wrong");
	property p_div; wr && addr == OFF_CLK_DIV |=> {dozeRatio, dozeEnable, frcPostscale,
		pllPostscale, pllPrescale} == {$past(wdata[14:6]), $past(wdata[4:0])}; endproperty
	a_div: assert property (p_div) else $error("divisor fields wrong");
	property p_fbd; wr && addr == OFF_PLL_FBD |=> pllFeedbackDiv == $past(wdata[8:0]); endproperty
	a_fbd: assert property (p_fbd) else $error("feedback divisor wrong");
	property p_tun; wr && addr == OFF_FRC_TUN |=> frcTuning == $past(wdata[5:0]); endproperty
	a_tun: assert property (p_tun) else $error("tuning value wrong");
endmodule // osc_ctrl_chk

bind oscillator_control_status_regs osc_ctrl_chk osc_ctrl_chk_inst (.clk, .resetn, .addr,
	.wdata, .wr, .rd, .rdata, .currentSource, .switchBusy, .pinSelectLock, .secondaryOscEnable,
	.dozeRatio, .dozeEnable, .frcPostscale, .pllPostscale, .pllPrescale, .pllFeedbackDiv,
	.frcTuning);

// *** oscillator_control_status_regs_test.sv ***
// Self-checking bench for the oscillator control register block.
// Drives the register port directly; the checker is bound in separately.
module oscillator_control_status_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import osc_ctrl_pkg::*;
	typedef struct {addr_t a; data_t d; data_t e;} row_s;
	logic clk = 0, resetn = 0, wr = 0, rd = 0, pllLockIn = 0, clockFailIn = 0;
	addr_t addr = 4'h0;
	data_t wdata = 16'h0000;
	data_t rdata;
	logic [2:0] initialSourceSel = 3'h7, currentSource;
	logic switchBusy;
	int n_errors = 0, samples_checked = 0, cycles = 0;
	row_s rows[9] = '{'{4'h1, 16'hFFFF, 16'h7FDF}, '{4'h1, 16'h0000, 16'h0000},
		'{4'h1, 16'hA5A5, 16'h2585}, '{4'h2, 16'hFFFF, 16'h01FF}, '{4'h2, 16'h0155, 16'h0155},
		'{4'h3, 16'hFFFF, 16'h003F}, '{4'h3, 16'h002A, 16'h002A}, '{4'h4, 16'hFFFF, 16'h0000},
		'{4'hF, 16'h1234, 16'h0000}};
	oscillator_control_status_regs oscillator_control_status_regs_inst (.clk, .resetn, .addr,
		.wdata, .wr, .rd, .rdata, .initialSourceSel, .pllLockIn, .clockFailIn, .currentSource,
		.switchBusy, .pinSelectLock(), .secondaryOscEnable(), .dozeRatio(), .dozeEnable(),
		.frcPostscale(), .pllPostscale(), .pllPrescale(), .pllFeedbackDiv(), .frcTuning());
	// Clock and hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic check(input data_t got, input data_t exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrReg(input addr_t a, input data_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdCheck(input addr_t a, input data_t e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check(rdata, e);
	endtask
	task automatic doReset(input logic [2:0] src);
		@(posedge clk);
		resetn <= 1'b0;
		initialSourceSel <= src;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
	endtask
	task automatic waitIdle();
		int i;
		i = 0;
		@(negedge clk);
		while (switchBusy !== 1'b0 && i < 40) begin
			@(negedge clk);
			i++;
		end
		check(data_t'(i), data_t'(SWITCH_CYCLES + 1));
	endtask
	task automatic conclude();
		$display("checked %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial begin
		doReset(3'h7);
		rdCheck(OFF_OSC_CTRL, 16'h7700);
		for (int a = 1; a < 4; a++) rdCheck(addr_t'(a), 16'h0000);
		foreach (rows[i]) begin
			wrReg(rows[i].a, rows[i].d);
			rdCheck(rows[i].a, rows[i].e);
		end
		$display("table done");
		for (int c = 0; c < 8; c++) begin
			wrReg(OFF_OSC_CTRL, {5'h00, 3'(c), 8'h01});
			waitIdle();
			check(data_t'(currentSource), data_t'(c));
			rdCheck(OFF_OSC_CTRL, {1'b0, 3'(c), 1'b0, 3'(c), 8'h00});
		end
		$display("switch done");
		wrReg(OFF_OSC_CTRL, 16'h7020);
		rdCheck(OFF_OSC_CTRL, 16'h7000);
		@(posedge clk);
		pllLockIn <= 1'b1;
		clockFailIn <= 1'b1;
		repeat (5) @(posedge clk);
		rdCheck(OFF_OSC_CTRL, 16'h7028);
		wrReg(OFF_OSC_CTRL, 16'h0708);
		rdCheck(OFF_OSC_CTRL, 16'h7728);
		wrReg(OFF_OSC_CTRL, 16'h0700);
		rdCheck(OFF_OSC_CTRL, 16'h7720);
		wrReg(OFF_OSC_CTRL, 16'h07C2);
		rdCheck(OFF_OSC_CTRL, 16'h77E2);
		wrReg(OFF_OSC_CTRL, 16'h0301);
		repeat (15) @(posedge clk);
		@(negedge clk);
		check(data_t'(switchBusy), 16'h0000);
		rdCheck(OFF_OSC_CTRL, 16'h73A0);
		$display("lock done");
		@(posedge clk);
		pllLockIn <= 1'b0;
		clockFailIn <= 1'b0;
		doReset(3'h2);
		rdCheck(OFF_OSC_CTRL, 16'h2200);
		for (int a = 1; a < 4; a++) rdCheck(addr_t'(a), 16'h0000);
		wrReg(OFF_OSC_CTRL, 16'h0501);
		waitIdle();
		check(data_t'(currentSource), 16'h0005);
		$display("reset done");
		conclude();
	end
endmodule // oscillator_control_status_regs_test
